//--- hw/spip_pkg.sv
// spip_pkg: register map, field positions, timing and shared helpers
// for the serial peripheral port and its link partner.
// assumes clk is the oscillator, 50 MHz.
package spip_pkg;

    // register addresses on the special function register port
    localparam logic [7:0] ADDR_DATA = 8'h86;
    localparam logic [7:0] ADDR_STAT = 8'hAA;
    localparam logic [7:0] ADDR_CTRL = 8'hD5;

    // reset values
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // control register fields
    localparam int CTRL_IRQ_EN = 7;
    localparam int CTRL_EN     = 6;
    localparam int CTRL_MASTER = 4;
    localparam int CTRL_CLOCK_POLARITY_SEL   = 3;
    localparam int CTRL_CLOCK_PHASE_SEL   = 2;
    localparam int CTRL_RATE   = 0;

    // status register fields
    localparam int STAT_DONE   = 7;
    localparam int STAT_WRITE_COLLISION_FLAG   = 6;
    localparam int STAT_LOAD_ENABLE_STATUS   = 5;
    localparam int STAT_SOD    = 1;
    localparam int STAT_ENH    = 0;

    // bits per transfer
    localparam int          NBITS    = 8;
    localparam logic [2:0]  LAST_BIT = 3'(NBITS - 1);

    // timing: serial clock period of at least four oscillator periods
    localparam int CLK_NS      = 20;
    localparam int OSC_NS      = CLK_NS;
    localparam int SCK_MIN_OSC = 4;
    localparam int SCK_MIN_NS  = SCK_MIN_OSC * OSC_NS;
    localparam int SCK_MIN_CYC = (SCK_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] HALF_BASE = 5'(SCK_MIN_CYC / 2);

    typedef enum {ST_IDLE, ST_SEL, ST_SHIFT} spip_state_t;

    // half period in clocks for a rate code: 2, 4, 8 or 16
    function automatic logic [4:0] spip_half(input logic [1:0] rate);
        return HALF_BASE << rate;
    endfunction

endpackage

//--- hw/spip_link_if.sv
// spip_link_if: the four link wires between the port and its partner.
// each end drives output and enable; undriven lines rest high.
`timescale 1ns/1ps
interface spip_link_if;
    logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
    logic dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_n_oe;
    logic host_sck_o, host_sck_oe, host_mosi_o, host_mosi_oe;
    logic host_miso_o, host_miso_oe, host_ss_n_o, host_ss_n_oe;
    logic sck, mosi, miso, ss_n;

    assign sck  = dev_sck_oe   ? dev_sck_o   :
                  host_sck_oe  ? host_sck_o  : 1'b1;
    assign mosi = dev_mosi_oe  ? dev_mosi_o  :
                  host_mosi_oe ? host_mosi_o : 1'b1;
    assign miso = dev_miso_oe  ? dev_miso_o  :
                  host_miso_oe ? host_miso_o : 1'b1;
    assign ss_n = dev_ss_n_oe  ? dev_ss_n_o  :
                  host_ss_n_oe ? host_ss_n_o : 1'b1;

    modport dev (input sck, mosi, miso, ss_n,
                 output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
                 dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_n_oe);
    modport host (input sck, mosi, miso, ss_n,
                  output host_sck_o, host_sck_oe, host_mosi_o,
                  host_mosi_oe, host_miso_o, host_miso_oe,
                  host_ss_n_o, host_ss_n_oe);
endinterface // spip_link_if

//--- hw/spip_peer.sv
// spip_peer: the far end of the link, master or slave, with byte
// streams on its user side. assumes the port's link interface.
`timescale 1ns/1ps
module spip_peer
    import spip_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // configuration
    input  wire logic       is_master,
    input  wire logic       enable,
    input  wire logic       clock_polarity_sel,
    input  wire logic       clock_phase_sel,
    input  wire logic [1:0] rate_sel,
    // bytes to send
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // bytes received
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    // link
    spip_link_if.host       link
);
    logic [1:0]  sck_sy_r, mosi_sy_r, miso_sy_r, ss_sy_r;
    logic        sck_d_r, smp_r, obit_r, ph_r, have_r, rdy_r;
    logic [7:0]  sh_r, q0_r, q1_r;
    logic        v0_r, v1_r;
    logic [2:0]  cnt_r;
    logic [4:0]  div_r;
    logic        sck_o_r, mosi_o_r, miso_o_r, miso_oe_r, ss_o_r, m_oe_r;
    spip_state_t st_r, st_nxt;

    wire       sck_i    = sck_sy_r[1];
    wire       ss_low   = ~ss_sy_r[1];
    wire       in_prog  = st_r == ST_SHIFT;
    wire       take     = tx_valid & rdy_r;
    wire       full     = v0_r & v1_r;
    wire       tick     = is_master & in_prog &
                          (div_r == spip_half(rate_sel) - 5'h01);
    wire       s_edge   = ~is_master & (st_r != ST_IDLE) &
                          (sck_i != sck_d_r);
    wire       lead     = tick & ~ph_r | s_edge & (sck_i != clock_polarity_sel);
    wire       trail    = tick & ph_r | s_edge & (sck_i == clock_polarity_sel);
    wire       in_bit   = is_master ? miso_sy_r[1] : mosi_sy_r[1];
    wire       new_bit  = clock_phase_sel ? in_bit : smp_r;
    wire       last     = trail & (cnt_r == LAST_BIT);
    wire [7:0] rxb      = {sh_r[6:0], new_bit};
    wire       out_bit  = clock_phase_sel ? obit_r : sh_r[7];
    wire       pop      = v0_r & rx_ready;
    wire       start    = is_master & enable & take;
    // master waits for a free slot so a stalled reader loses nothing
    wire       rdy_nxt  = enable & (st_r == ST_IDLE) & ~take & ~have_r &
                          (is_master ? ~full : 1'b1);

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:  if (start)
                          st_nxt = ST_SHIFT;
                      else if (~is_master & ss_low)
                          st_nxt = ST_SEL;
            ST_SEL:   if (lead)
                          st_nxt = ST_SHIFT;
            ST_SHIFT: if (last)
                          st_nxt = is_master ? ST_IDLE : ST_SEL;
            default:  st_nxt = ST_IDLE;
        endcase
        if (~enable | (~is_master & ~ss_low) | (is_master & st_r == ST_SEL))
            st_nxt = ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        sck_sy_r  <= {sck_sy_r[0], link.sck};
        mosi_sy_r <= {mosi_sy_r[0], link.mosi};
        miso_sy_r <= {miso_sy_r[0], link.miso};
        ss_sy_r   <= {ss_sy_r[0], link.ss_n};
        sck_d_r   <= sck_sy_r[1];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r  <= ST_IDLE;
            cnt_r <= 3'h0;
            div_r <= 5'h00;
            ph_r  <= 1'b0;
            smp_r <= 1'b0;
            obit_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_nxt == ST_IDLE)
            begin
                cnt_r <= 3'h0;
                div_r <= 5'h00;
                ph_r  <= 1'b0;
            end
            else
            begin
                div_r <= tick ? 5'h00 : (in_prog ? div_r + 5'h01 : 5'h00);
                ph_r  <= ph_r ^ tick;
                if (trail)
                    cnt_r <= cnt_r + 3'h1;
            end
            if (lead)
            begin
                smp_r  <= in_bit;
                obit_r <= sh_r[7];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sh_r   <= DATA_RST;
            have_r <= 1'b0;
            rdy_r  <= 1'b0;
        end
        else
        begin
            rdy_r <= rdy_nxt;
            if (take)
                sh_r <= tx_data;
            else if (trail)
                sh_r <= rxb;
            have_r <= (have_r | (take & ~is_master)) & ~last;
        end
    end

    // two-entry receive buffer; q0 is the head seen by the reader
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
            q0_r <= 8'h00;
            q1_r <= 8'h00;
        end
        else if (pop)
        begin
            q0_r <= v1_r ? q1_r : rxb;
            v0_r <= v1_r | last;
            q1_r <= rxb;
            v1_r <= v1_r & last;
        end
        else if (last & ~v0_r)
        begin
            q0_r <= rxb;
            v0_r <= 1'b1;
        end
        else if (last & ~v1_r)
        begin
            q1_r <= rxb;
            v1_r <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            m_oe_r    <= 1'b0;
            sck_o_r   <= 1'b0;
            ss_o_r    <= 1'b1;
            mosi_o_r  <= 1'b1;
            miso_o_r  <= 1'b1;
            miso_oe_r <= 1'b0;
        end
        else
        begin
            // the system should enable this master before any slave
            m_oe_r    <= enable & is_master;
            sck_o_r   <= (~in_prog | ~is_master) ? clock_polarity_sel :
                         lead ? ~clock_polarity_sel : trail ? clock_polarity_sel : sck_o_r;
            ss_o_r    <= ~(is_master & in_prog);
            mosi_o_r  <= out_bit;
            miso_o_r  <= out_bit;
            miso_oe_r <= enable & ~is_master & ss_low;
        end
    end

    assign tx_ready          = rdy_r;
    assign rx_valid          = v0_r;
    assign rx_data           = q0_r;
    assign link.host_sck_o   = sck_o_r;
    assign link.host_sck_oe  = m_oe_r;
    assign link.host_mosi_o  = mosi_o_r;
    assign link.host_mosi_oe = m_oe_r;
    assign link.host_ss_n_o  = ss_o_r;
    assign link.host_ss_n_oe = m_oe_r;
    assign link.host_miso_o  = miso_o_r;
    assign link.host_miso_oe = miso_oe_r;
endmodule // spip_peer

//--- hw/spip_port.sv
// spip_port: serial peripheral port, master or slave, with data,
// status and control registers on the special function register port.
// assumes link inputs are asynchronous to clk and resynchronised here.
`timescale 1ns/1ps
module spip_port
    import spip_pkg::*;
(
    // clock and resets
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       warm_rst,
    // special function register access
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]      sfr_rdata,
    // shared serial interrupt
    input  wire logic       serial_irq_enable,
    input  wire logic       uart_rx_flag,
    input  wire logic       uart_tx_flag,
    output logic            serial_irq,
    // link
    spip_link_if.dev        link
);
    logic [1:0]  sck_sy_r, mosi_sy_r, miso_sy_r, ss_sy_r;
    logic        sck_d_r, smp_r, obit_r, ph_r;
    logic [7:0]  ctrl_r, sh_r, rx_r, txbuf_r, rdata_r, stat_v;
    logic        sod_r, enh_r, done_r, write_collision_flag_r, txfull_r, armed_r, irq_r;
    logic [2:0]  cnt_r;
    logic [4:0]  div_r;
    logic        sck_o_r, mosi_o_r, miso_o_r, miso_oe_r, ss_o_r, m_oe_r;
    spip_state_t st_r, st_nxt;

    // warm reset spares only the data registers
    wire       rst_w    = sys_rst | warm_rst;
    wire       irq_en   = ctrl_r[CTRL_IRQ_EN];
    wire       en       = ctrl_r[CTRL_EN];
    wire       master   = ctrl_r[CTRL_MASTER];
    wire       clock_polarity_sel     = ctrl_r[CTRL_CLOCK_POLARITY_SEL];
    wire       clock_phase_sel     = ctrl_r[CTRL_CLOCK_PHASE_SEL];
    wire [1:0] rate     = ctrl_r[CTRL_RATE +: 2];
    wire       sck_i    = sck_sy_r[1];
    wire       ss_low   = ~ss_sy_r[1];
    wire       wr_data  = sfr_wr & (sfr_addr == ADDR_DATA);
    wire       rd_data  = sfr_rd & (sfr_addr == ADDR_DATA);
    wire       rd_stat  = sfr_rd & (sfr_addr == ADDR_STAT);
    wire       wr_stat  = sfr_wr & (sfr_addr == ADDR_STAT);
    wire       rd_ctrl  = sfr_rd & (sfr_addr == ADDR_CTRL);
    wire       wr_ctrl  = sfr_wr & (sfr_addr == ADDR_CTRL);
    wire       in_prog  = st_r == ST_SHIFT;
    wire       tick     = master & in_prog &
                          (div_r == spip_half(rate) - 5'h01);
    wire       s_edge   = ~master & (st_r != ST_IDLE) &
                          (sck_i != sck_d_r);
    wire       lead     = tick & ~ph_r | s_edge & (sck_i != clock_polarity_sel);
    wire       trail    = tick & ph_r | s_edge & (sck_i == clock_polarity_sel);
    wire       in_bit   = master ? miso_sy_r[1] : mosi_sy_r[1];
    wire       new_bit  = clock_phase_sel ? in_bit : smp_r;
    wire       last     = trail & (cnt_r == LAST_BIT);
    wire [7:0] rxb      = {sh_r[6:0], new_bit};
    wire       out_bit  = clock_phase_sel ? obit_r : sh_r[7];
    wire       wr_idle  = ~enh_r & wr_data & ~in_prog;
    wire       load_buf = enh_r & txfull_r & ~wr_data & ~in_prog & en;
    wire       start    = master & en & (st_r == ST_IDLE) &
                          (wr_idle | load_buf);
    wire       clr      = armed_r & (wr_data | rd_data);
    wire       load_enable_status     = enh_r & in_prog & ~cnt_r[2];
    wire [7:0] rd_v     = rd_data ? rx_r : rd_stat ? stat_v :
                          rd_ctrl ? ctrl_r : 8'h00;

    always_comb
    begin
        stat_v            = 8'h00;
        stat_v[STAT_DONE] = done_r;
        stat_v[STAT_WRITE_COLLISION_FLAG] = enh_r ? txfull_r : write_collision_flag_r;
        stat_v[STAT_LOAD_ENABLE_STATUS] = load_enable_status;
        stat_v[STAT_SOD]  = sod_r;
        stat_v[STAT_ENH]  = enh_r;
    end

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:  if (start)
                          st_nxt = ST_SHIFT;
                      else if (~master & en & ss_low)
                          st_nxt = ST_SEL;
            ST_SEL:   if (lead)
                          st_nxt = ST_SHIFT;
            ST_SHIFT: if (last)
                          st_nxt = master ? ST_IDLE : ST_SEL;
            default:  st_nxt = ST_IDLE;
        endcase
        // a dropped select or disable aborts a partial byte
        if (~en | (~master & ~ss_low) | (master & st_r == ST_SEL))
            st_nxt = ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        sck_sy_r  <= {sck_sy_r[0], link.sck};
        mosi_sy_r <= {mosi_sy_r[0], link.mosi};
        miso_sy_r <= {miso_sy_r[0], link.miso};
        ss_sy_r   <= {ss_sy_r[0], link.ss_n};
        sck_d_r   <= sck_sy_r[1];
    end

    // no interlock: changing clock format mid-byte is software's risk
    always_ff @(posedge clk)
    begin
        if (rst_w)
        begin
            ctrl_r <= CTRL_RST;
            sod_r  <= 1'b0;
            enh_r  <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= sfr_wdata;
            if (wr_stat)
            begin
                sod_r <= sfr_wdata[STAT_SOD];
                enh_r <= sfr_wdata[STAT_ENH];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_w)
        begin
            st_r   <= ST_IDLE;
            cnt_r  <= 3'h0;
            div_r  <= 5'h00;
            ph_r   <= 1'b0;
            smp_r  <= 1'b0;
            obit_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_nxt == ST_IDLE)
            begin
                cnt_r <= 3'h0;
                div_r <= 5'h00;
                ph_r  <= 1'b0;
            end
            else
            begin
                div_r <= tick ? 5'h00 : (in_prog ? div_r + 5'h01 : 5'h00);
                ph_r  <= ph_r ^ tick;
                if (trail)
                    cnt_r <= cnt_r + 3'h1;
            end
            if (lead)
            begin
                smp_r  <= in_bit;
                obit_r <= sh_r[7];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sh_r <= DATA_RST;
            rx_r <= DATA_RST;
        end
        else if (~warm_rst)
        begin
            if (wr_idle)
                sh_r <= sfr_wdata;
            else if (load_buf)
                sh_r <= txbuf_r;
            else if (trail)
                sh_r <= rxb;
            if (last)
                rx_r <= rxb;
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst_w)
        begin
            done_r   <= 1'b0;
            write_collision_flag_r   <= 1'b0;
            txfull_r <= 1'b0;
            txbuf_r  <= 8'h00;
            armed_r  <= 1'b0;
        end
        else
        begin
            done_r   <= last | (done_r & ~clr);
            write_collision_flag_r   <= (~enh_r & wr_data & in_prog) |
                        (write_collision_flag_r & ~clr);
            txfull_r <= (enh_r & wr_data) |
                        (txfull_r & ~load_buf);
            if (enh_r & wr_data)
                txbuf_r <= sfr_wdata;
            armed_r  <= rd_stat | (armed_r & ~(wr_data | rd_data));
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_w)
        begin
            m_oe_r    <= 1'b0;
            sck_o_r   <= 1'b0;
            ss_o_r    <= 1'b1;
            mosi_o_r  <= 1'b1;
            miso_o_r  <= 1'b1;
            miso_oe_r <= 1'b0;
        end
        else
        begin
            m_oe_r    <= en & master;
            sck_o_r   <= (~in_prog | ~master) ? clock_polarity_sel :
                         lead ? ~clock_polarity_sel : trail ? clock_polarity_sel : sck_o_r;
            ss_o_r    <= ~(master & in_prog);
            mosi_o_r  <= out_bit;
            miso_o_r  <= out_bit;
            miso_oe_r <= en & ~master & ss_low & ~sod_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_w)
        begin
            rdata_r <= 8'h00;
            irq_r   <= 1'b0;
        end
        else
        begin
            irq_r <= serial_irq_enable & (uart_rx_flag | uart_tx_flag |
                     (done_r & irq_en));
            if (sfr_rd)
                rdata_r <= rd_v;
        end
    end

    assign sfr_rdata        = rdata_r;
    assign serial_irq       = irq_r;
    assign link.dev_sck_o   = sck_o_r;
    assign link.dev_sck_oe  = m_oe_r;
    assign link.dev_mosi_o  = mosi_o_r;
    assign link.dev_mosi_oe = m_oe_r;
    assign link.dev_ss_n_o  = ss_o_r;
    assign link.dev_ss_n_oe = m_oe_r;
    assign link.dev_miso_o  = miso_o_r;
    assign link.dev_miso_oe = miso_oe_r;
endmodule // spip_port

//--- tb/spip_port_assertions.sv
// spip_port_assertions: timing checks on the link wires between ends.
// assumes it sits beside the link interface in the top bench.
`timescale 1ns/1ps
module spip_port_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // resolved link
    input wire logic sck,
    input wire logic ss_n,
    // enables of both ends
    input wire logic dev_sck_oe,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic host_sck_oe,
    input wire logic host_mosi_oe,
    input wire logic host_miso_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       sck_r;
    logic [4:0] edges_r;
    logic [4:0] edges_nxt;
    // the edge of the current cycle is added in the check itself
    assign edges_nxt = ss_n ? 5'h00 : edges_r + 5'(sck != sck_r);
    always_ff @(posedge clk)
    begin
        sck_r   <= sck;
        edges_r <= sys_rst ? 5'h00 : edges_nxt;
    end
    sequence held_low;
        !ss_n [*8];
    endsequence
    sequence deselected;
        ss_n [*6];
    endsequence
    sck_half_a: assert property ($changed(sck) |=> $stable(sck))
        else $error("serial clock half period too short");
    frame_bits_a: assert property (
        $rose(ss_n) |-> edges_r + 5'(sck != sck_r) == 5'h10)
        else $error("frame did not carry sixteen clock edges");
    frame_len_a: assert property ($fell(ss_n) |-> held_low)
        else $error("select low for too few cycles");
    sel_lead_a: assert property ($fell(ss_n) |-> $stable(sck))
        else $error("clock moved as select fell");
    dev_miso_off_a: assert property (
        deselected |-> !dev_miso_oe)
        else $error("port drives miso while deselected");
    host_miso_off_a: assert property (
        deselected |-> !host_miso_oe)
        else $error("peer drives miso while deselected");
    dev_drive_a: assert property (dev_mosi_oe |-> dev_sck_oe)
        else $error("port drives mosi without clock");
    host_drive_a: assert property (host_mosi_oe |-> host_sck_oe)
        else $error("peer drives mosi without clock");
endmodule // spip_port_assertions

//--- tb/tb_spi_master_slave_port.sv
// tb_spi_master_slave_port: port and peer joined by the link interface.
// assumes 50 MHz clk; bench drives inputs on the falling edge.
`timescale 1ns/1ps
`define CHK(a, e) \
    begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module tb_spi_master_slave_port;
    import spip_pkg::*;
    logic       clk = 1'b0, sys_rst = 1'b1, warm_rst = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic       sfr_wr = 1'b0, sfr_rd = 1'b0, serial_irq;
    logic       sie = 1'b0, urx = 1'b0, utx = 1'b0;
    logic       pm = 1'b0, pen = 1'b0, clock_polarity_sel = 1'b0, clock_phase_sel = 1'b0;
    logic [1:0] prate = 2'h2;
    logic       tx_valid = 1'b0, tx_ready, rx_valid, rx_ready = 1'b0;
    logic [7:0] tx_data = 8'h00, rx_data, v, d, b, c;
    int         err_count = 0, checked = 0;
    spip_link_if spip_link_if_i();
    spip_port spip_port_i (.clk(clk), .sys_rst(sys_rst),
        .warm_rst(warm_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .serial_irq_enable(sie), .uart_rx_flag(urx),
        .uart_tx_flag(utx), .serial_irq(serial_irq),
        .link(spip_link_if_i.dev));
    spip_peer spip_peer_i (.clk(clk), .sys_rst(sys_rst), .is_master(pm),
        .enable(pen), .clock_polarity_sel(clock_polarity_sel), .clock_phase_sel(clock_phase_sel), .rate_sel(prate),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .link(spip_link_if_i.host));
    spip_port_assertions spip_port_assertions_i (.clk(clk),
        .sys_rst(sys_rst), .sck(spip_link_if_i.sck),
        .ss_n(spip_link_if_i.ss_n),
        .dev_sck_oe(spip_link_if_i.dev_sck_oe),
        .dev_mosi_oe(spip_link_if_i.dev_mosi_oe),
        .dev_miso_oe(spip_link_if_i.dev_miso_oe),
        .host_sck_oe(spip_link_if_i.host_sck_oe),
        .host_mosi_oe(spip_link_if_i.host_mosi_oe),
        .host_miso_oe(spip_link_if_i.host_miso_oe));
    initial forever #10 clk = ~clk;
    task automatic conclude();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = w;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        r      = sfr_rdata;
    endtask
    // polling status also arms the flag clear for the next data access
    task automatic wait_done();
        logic [7:0] s;
        int         n;
        s = 8'h00;
        n = 0;
        while (s[STAT_DONE] !== 1'b1 && n < 300)
        begin
            rd(ADDR_STAT, s);
            n++;
        end
        `CHK(s[STAT_DONE], 1'b1)
    endtask
    task automatic peer_tx(input logic [7:0] w);
        int n;
        n = 0;
        @(negedge clk);
        tx_data  = w;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 500)
            err_count++;
        @(negedge clk);
        tx_valid = 1'b0;
    endtask
    task automatic peer_rx(output logic [7:0] r);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 900)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 900)
            err_count++;
        r        = rx_data;
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial
    begin
        v = 8'($urandom(86756));
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        rd(ADDR_DATA, v);
        `CHK(v, DATA_RST)
        rd(ADDR_CTRL, v);
        `CHK(v, CTRL_RST)
        rd(8'h00, v);
        `CHK(v, 8'h00)
        wr(ADDR_STAT, 8'hE0);
        rd(ADDR_STAT, v);
        `CHK(v, 8'h00)
        // port master, peer slave, all four clock formats
        for (int i = 0; i < 4; i++)
        begin
            pen  = 1'b0;
            clock_polarity_sel = i[1];
            clock_phase_sel = i[0];
            c    = {i[1], 3'b001, i[1], i[0], 1'b1, i[0]};
            wr(ADDR_CTRL, 8'h00);
            wr(ADDR_CTRL, c);
            wr(ADDR_CTRL, c | 8'h40);
            pen = 1'b1;
            sie = 1'($urandom);
            urx = 1'($urandom);
            d   = 8'($urandom);
            b   = 8'($urandom);
            peer_tx(b);
            wr(ADDR_DATA, d);
            wait_done();
            `CHK(serial_irq, sie & (urx | c[7]))
            rd(ADDR_DATA, v);
            `CHK(v, b)
            peer_rx(v);
            `CHK(v, d)
            rd(ADDR_STAT, v);
            `CHK(v[STAT_DONE], 1'b0)
            `CHK(serial_irq, sie & urx)
        end
        // write during a transfer in normal mode
        peer_tx(b);
        wr(ADDR_DATA, d);
        repeat (20) @(negedge clk);
        wr(ADDR_DATA, ~d);
        rd(ADDR_STAT, v);
        `CHK(v[STAT_WRITE_COLLISION_FLAG], 1'b1)
        wait_done();
        rd(ADDR_DATA, v);
        peer_rx(v);
        `CHK(v, d)
        rd(ADDR_STAT, v);
        `CHK(v[7:6], 2'b00)
        // enhanced mode with the peer's receive side stalled
        wr(ADDR_STAT, 8'h01);
        b = 8'($urandom);
        wr(ADDR_DATA, d);
        wr(ADDR_DATA, ~d);
        rd(ADDR_STAT, v);
        `CHK(v[STAT_WRITE_COLLISION_FLAG], 1'b1)
        `CHK(v[STAT_LOAD_ENABLE_STATUS], 1'b1)
        wr(ADDR_DATA, b);
        wait_done();
        rd(ADDR_STAT, v);
        `CHK(v[7:6], 2'b10)
        rd(ADDR_DATA, v);
        wait_done();
        rd(ADDR_STAT, v);
        `CHK(v[STAT_LOAD_ENABLE_STATUS], 1'b0)
        rd(ADDR_DATA, v);
        peer_rx(v);
        `CHK(v, d)
        peer_rx(v);
        `CHK(v, b)
        // port slave, peer master; second pass with output disabled
        pen   = 1'b0;
        clock_polarity_sel  = 1'b0;
        clock_phase_sel  = 1'b0;
        pm    = 1'b1;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_STAT, 8'h00);
        pen = 1'b1;
        wr(ADDR_CTRL, 8'h40);
        for (int j = 0; j < 2; j++)
        begin
            wr(ADDR_STAT, j[0] ? 8'h02 : 8'h00);
            d = 8'($urandom);
            b = 8'($urandom);
            wr(ADDR_DATA, d);
            peer_tx(b);
            wait_done();
            rd(ADDR_DATA, v);
            `CHK(v, b)
            peer_rx(v);
            `CHK(v, j[0] ? 8'hFF : d)
        end
        // warm reset spares the data register, cold reset clears it
        @(negedge clk);
        warm_rst = 1'b1;
        repeat (4) @(negedge clk);
        warm_rst = 1'b0;
        rd(ADDR_DATA, v);
        `CHK(v, b)
        rd(ADDR_CTRL, v);
        `CHK(v, CTRL_RST)
        sys_rst = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        rd(ADDR_DATA, v);
        `CHK(v, DATA_RST)
        conclude();
    end
endmodule // tb_spi_master_slave_port
